/* sispp_pkg.sv */
`default_nettype none
package sispp_pkg;
    // Array geometry
    localparam int FLASH_AW = 14;
    localparam int PAGE_AW = 7;
    localparam int EE_AW = 10;
    localparam int EXT_W = 8;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int BIT_CNT_W = 3;
    localparam int IDX_W = 2;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [IDX_W-1:0] IDX_ADDR_LO = 2'h2;
    localparam logic [IDX_W-1:0] IDX_DATA = 2'h3;

    // Instruction encodings
    localparam logic [7:0] OP_PROG_EN1 = 8'hac;
    localparam logic [7:0] OP_PROG_EN2 = 8'h53;
    localparam logic [7:0] OP_ERASE_MASK = 8'he0;
    localparam logic [7:0] OP_ERASE_CODE = 8'h80;
    localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
    localparam logic [7:0] OP_RD_FLASH = 8'h20;
    localparam logic [7:0] OP_LD_PAGE = 8'h40;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_RD_EE = 8'ha0;
    localparam logic [7:0] OP_WR_EE = 8'hc0;
    localparam logic [7:0] OP_HI_MASK = 8'h08;
    localparam int OP_HI_POS = 3;
    localparam int PAGE_WORD_POS = 0;

    // Reset and erased values
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [7:0] TX_RESET = 8'h00;
    localparam logic [EXT_W-1:0] EXT_RESET = 8'h00;

    // Timing
    localparam real CLK_MHZ = 200.0;
    localparam real T_WD_FLASH_MS = 4.5;
    localparam real T_WD_EEPROM_MS = 9.0;
    localparam real T_WD_ERASE_MS = 9.0;
    localparam int TMR_W = 21;
    localparam int WAIT_FLASH_CYC = int'(T_WD_FLASH_MS * CLK_MHZ * 1000.0);
    localparam int WAIT_EEPROM_CYC = int'(T_WD_EEPROM_MS * CLK_MHZ * 1000.0);
    localparam int WAIT_ERASE_CYC = int'(T_WD_ERASE_MS * CLK_MHZ * 1000.0);
endpackage : sispp_pkg
`default_nettype wire

/* sispp_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sispp_core_if;
    import sispp_pkg::*;
    // Shifter group
    logic clr;
    logic byte_vld;
    logic [BYTE_W-1:0] rx_byte;
    logic tx_load;
    logic [BYTE_W-1:0] tx_byte;
    // Memory group
    logic ld_en;
    logic ld_hi;
    logic [PAGE_AW-1:0] ld_word;
    logic [BYTE_W-1:0] ld_data;
    logic page_go;
    logic [FLASH_AW-1:0] page_addr;
    logic erase_go;
    logic ee_we;
    logic [EE_AW-1:0] ee_addr;
    logic [BYTE_W-1:0] ee_wdata;
    logic [FLASH_AW-1:0] fl_rd_addr;
    logic [WORD_W-1:0] fl_rd_q;
    logic [BYTE_W-1:0] ee_rd_q;
    logic walking;

    modport ctl(output clr, tx_load, tx_byte, ld_en, ld_hi, ld_word, ld_data, page_go, page_addr,
                erase_go, ee_we, ee_addr, ee_wdata, fl_rd_addr,
                input byte_vld, rx_byte, fl_rd_q, ee_rd_q, walking);
    modport shf(input clr, tx_load, tx_byte, output byte_vld, rx_byte);
    modport mem(input ld_en, ld_hi, ld_word, ld_data, page_go, page_addr, erase_go, ee_we, ee_addr,
                ee_wdata, fl_rd_addr, output fl_rd_q, ee_rd_q, walking);
endinterface : sispp_core_if
`default_nettype wire

/* sispp_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module sispp_shift
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    sispp_core_if.shf bus
);
    import sispp_pkg::*;

    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic sdi_s1_q, sdi_s2_q;
    logic [BIT_CNT_W-1:0] bit_cnt_q;
    logic [BYTE_W-1:0] rx_q;
    logic vld_q;
    logic [BYTE_W-1:0] tx_q;
    logic sck_rise, sck_fall;

    // Pin synchronisers; edges are found only after the second stage
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
        end
        else
        begin
            sck_s1_q <= sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            sdi_s1_q <= sdi;
            sdi_s2_q <= sdi_s1_q;
        end
    end

    assign sck_rise = sck_s2_q & ~sck_s3_q;
    assign sck_fall = ~sck_s2_q & sck_s3_q;

    // Receive: data and clock share the same delay, so sampling stays aligned
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_q <= '0;
            rx_q <= '0;
            vld_q <= 1'b0;
        end
        else
        begin
            vld_q <= 1'b0;
            if (bus.clr)
                bit_cnt_q <= '0;
            else if (sck_rise)
            begin
                rx_q <= {rx_q[BYTE_W-2:0], sdi_s2_q}; // [RL3]
                bit_cnt_q <= bit_cnt_q + 3'h1;
                vld_q <= (bit_cnt_q == LAST_BIT);
            end
        end
    end

    assign bus.byte_vld = vld_q;
    assign bus.rx_byte = rx_q;

    // Transmit: MSB first, one bit per falling edge
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_q <= TX_RESET;
            sdo <= 1'b0;
        end
        else if (bus.clr)
        begin
            tx_q <= TX_RESET;
            sdo <= 1'b0;
        end
        else if (bus.tx_load)
            tx_q <= bus.tx_byte;
        else if (sck_fall)
        begin
            sdo <= tx_q[BYTE_W-1]; // [RL4]
            tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
        end
    end
endmodule : sispp_shift
`default_nettype wire

/* sispp_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module sispp_mem
(
    input wire logic ref_clk,
    input wire logic rst,
    sispp_core_if.mem bus
);
    import sispp_pkg::*;

    typedef enum logic [1:0] {WALK_IDLE, WALK_ERASE, WALK_PAGE} sispp_walk_e;

    logic [WORD_W-1:0] flash_mem [2**FLASH_AW];
    logic [WORD_W-1:0] page_buf [2**PAGE_AW];
    logic [BYTE_W-1:0] ee_mem [2**EE_AW];
    sispp_walk_e walk_q;
    logic [FLASH_AW-1:0] cnt_q;
    logic [FLASH_AW-PAGE_AW-1:0] page_hi_q;

    // Erase and page commit walk one word per cycle, well inside the wait time
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            walk_q <= WALK_IDLE;
            cnt_q <= '0;
            page_hi_q <= '0;
        end
        else
        begin
            case (walk_q)
                WALK_IDLE:
                begin
                    cnt_q <= '0;
                    if (bus.erase_go)
                        walk_q <= WALK_ERASE;
                    else if (bus.page_go)
                    begin
                        walk_q <= WALK_PAGE;
                        page_hi_q <= bus.page_addr[FLASH_AW-1:PAGE_AW];
                    end
                end
                WALK_ERASE:
                begin
                    cnt_q <= cnt_q + FLASH_AW'(1);
                    if (&cnt_q)
                        walk_q <= WALK_IDLE;
                end
                WALK_PAGE:
                begin
                    cnt_q <= cnt_q + FLASH_AW'(1);
                    if (&cnt_q[PAGE_AW-1:0])
                        walk_q <= WALK_IDLE;
                end
                default: walk_q <= WALK_IDLE;
            endcase
        end
    end

    assign bus.walking = (walk_q != WALK_IDLE);

    // Array writes and registered reads
    always_ff @(posedge ref_clk)
    begin
        if (walk_q == WALK_ERASE)
        begin
            flash_mem[cnt_q] <= ERASED_WORD; // [RL6]
            if (cnt_q < FLASH_AW'(2**EE_AW))
                ee_mem[cnt_q[EE_AW-1:0]] <= ERASED_BYTE; // [RL6]
        end
        if (walk_q == WALK_PAGE)
        begin
            flash_mem[{page_hi_q, cnt_q[PAGE_AW-1:0]}] <= page_buf[cnt_q[PAGE_AW-1:0]]; // [RL14]
            page_buf[cnt_q[PAGE_AW-1:0]] <= ERASED_WORD;
        end
        if (bus.ld_en)
        begin
            if (bus.ld_hi)
                page_buf[bus.ld_word][WORD_W-1:BYTE_W] <= bus.ld_data; // [RL12]
            else
                page_buf[bus.ld_word][BYTE_W-1:0] <= bus.ld_data; // [RL12]
        end
        // Erase-then-write collapses to a plain overwrite of the byte
        if (bus.ee_we)
            ee_mem[bus.ee_addr] <= bus.ee_wdata; // [RL7] [RL17]
        bus.fl_rd_q <= flash_mem[bus.fl_rd_addr];
        bus.ee_rd_q <= ee_mem[bus.ee_addr];
    end
endmodule : sispp_mem
`default_nettype wire

/* sispp_top.sv */
// Notes on behaviour
// RL1 - Port works only while the reset pin is held low for the session.
// RL2 - Program and erase refused until Programming Enable completes after reset low.
// RL3 - Serial input bits sampled on rising serial clock edges.
// RL4 - Serial output bits shifted out on falling serial clock edges.
// RL5 - Programmer keeps each clock phase over two or three CPU clocks; here the high phase needs four or more for the output byte to load.
// RL6 - Chip erase sets every Flash and EEPROM location to 0xFF.
// RL7 - Each EEPROM write erases its byte first; no chip erase needed.
// RL8 - Programmer drives clock low then pulses reset high two CPU clocks.
// RL9 - Programmer waits 20ms after power-up before Programming Enable; the testbench waits 10 CPU clocks and the port does not time it.
// RL10 - Second enable byte 0x53 echoes out while the third byte arrives.
// RL11 - Programmer sends all four bytes; resyncs with reset pulse if echo missing.
// RL12 - Page buffer loaded one byte per instruction with seven word-address bits.
// RL13 - Programmer loads low data byte before high byte per word.
// RL14 - Write-page commits buffer at extended byte plus address bits 15..8; here address bits 13..7 pick the page and the extended byte is dropped.
// RL15 - Extended address byte kept until loaded again.
// RL16 - Programmer waits the Flash write delay unless it polls ready.
// RL17 - EEPROM written one byte per instruction; programmer waits between bytes.
// RL18 - Read returns addressed content; Flash read uses extended address byte; here it drops out of the 14-bit word address.
// RL19 - Reset pin released high ends programming and starts normal operation.
// RL20 - Programming Enable is bytes 0xAC, 0x53, then two don't-care bytes.
// RL21 - Chip erase is byte 0xAC then a byte matching 100x xxxx.
// RL22 - Before enable, other instructions ignored but bits still shift.
`timescale 1ns/1ps
`default_nettype none
module sispp_top
#(
    parameter int WAIT_FLASH_CYC_P = sispp_pkg::WAIT_FLASH_CYC,
    parameter int WAIT_EEPROM_CYC_P = sispp_pkg::WAIT_EEPROM_CYC,
    parameter int WAIT_ERASE_CYC_P = sispp_pkg::WAIT_ERASE_CYC
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_n_pin,
    input wire logic sck,
    input wire logic serial_program_in,
    output logic serial_program_out,
    output logic write_ready_indication,
    output logic prog_mode,
    output logic normal_run
);
    import sispp_pkg::*;

    localparam logic [TMR_W-1:0] WAIT_FLASH = TMR_W'(WAIT_FLASH_CYC_P);
    localparam logic [TMR_W-1:0] WAIT_EEPROM = TMR_W'(WAIT_EEPROM_CYC_P);
    localparam logic [TMR_W-1:0] WAIT_ERASE = TMR_W'(WAIT_ERASE_CYC_P);

    // Flash word address is the low FLASH_AW bits of extended, high and low bytes, so the extended byte drops out
    function automatic logic [FLASH_AW-1:0] flash_word(input logic [EXT_W-1:0] ext,
                                                     input logic [BYTE_W-1:0] hi,
                                                     input logic [BYTE_W-1:0] lo);
        logic [EXT_W+2*BYTE_W-1:0] full;
        full = {ext, hi, lo};
        return full[FLASH_AW-1:0];
    endfunction : flash_word

    sispp_core_if core();

    logic rstn_s1_q, rstn_s2_q;
    logic session;
    logic [IDX_W-1:0] idx_q;
    logic [BYTE_W-1:0] b1_q, b2_q, b3_q;
    logic en_q;
    logic [EXT_W-1:0] ext_q;
    logic [TMR_W-1:0] timer_q;
    logic busy;
    logic ready_q;
    logic normal_q;
    logic last_byte, exec, writes_ok;
    logic is_enable, is_erase, is_ldext, is_rdfl, is_ldpg, is_wrpg, is_rdee, is_wree;
    logic vld_d1_q, vld_d2_q;
    logic sel_rd_q, sel_fl_q, sel_hi_q;
    logic [BYTE_W-1:0] echo_q;
    logic [EE_AW+BYTE_W-1:0] ee_full;

    sispp_shift u_shift
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .sck(sck),
        .sdi(serial_program_in),
        .sdo(serial_program_out),
        .bus(core.shf)
    );

    sispp_mem u_mem
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .bus(core.mem)
    );

    // Reset pin synchroniser; pin assumed high (not programming) out of reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rstn_s1_q <= 1'b1;
            rstn_s2_q <= 1'b1;
        end
        else
        begin
            rstn_s1_q <= reset_n_pin;
            rstn_s2_q <= rstn_s1_q;
        end
    end

    assign session = ~rstn_s2_q; // [RL1]
    // A reset-pin pulse clears bit and byte counters, which is how sync is regained
    assign core.clr = ~session; // [RL1]

    // Byte position inside the four-byte instruction
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            idx_q <= '0;
        else if (!session)
            idx_q <= '0;
        else if (core.byte_vld)
            idx_q <= idx_q + 2'h1;
    end

    // First three bytes kept; the fourth is used straight from the shifter
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            b1_q <= '0;
            b2_q <= '0;
            b3_q <= '0;
        end
        else if (core.byte_vld)
        begin
            case (idx_q)
                2'h0: b1_q <= core.rx_byte;
                2'h1: b2_q <= core.rx_byte;
                2'h2: b3_q <= core.rx_byte;
                default: b3_q <= b3_q;
            endcase
        end
    end

    // Instruction decode from the stored opcode bytes
    assign is_enable = (b1_q == OP_PROG_EN1) && (b2_q == OP_PROG_EN2); // [RL20]
    assign is_erase = (b1_q == OP_PROG_EN1) && ((b2_q & OP_ERASE_MASK) == OP_ERASE_CODE); // [RL21]
    assign is_ldext = (b1_q == OP_LOAD_EXT);
    assign is_rdfl = ((b1_q & ~OP_HI_MASK) == OP_RD_FLASH);
    assign is_ldpg = ((b1_q & ~OP_HI_MASK) == OP_LD_PAGE);
    assign is_wrpg = (b1_q == OP_WR_PAGE);
    assign is_rdee = (b1_q == OP_RD_EE);
    assign is_wree = (b1_q == OP_WR_EE);

    assign last_byte = core.byte_vld && (idx_q == IDX_DATA);
    assign exec = last_byte && en_q; // [RL22]
    assign busy = (timer_q != '0) || core.walking;
    // Writes during a busy period are dropped rather than corrupting the array
    assign writes_ok = exec && !busy;

    // Programming enable latch, cleared whenever the reset pin goes high
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            en_q <= 1'b0;
        else if (!session)
            en_q <= 1'b0; // [RL2] [RL19]
        else if (last_byte && is_enable)
            en_q <= 1'b1; // [RL2]
    end

    // Extended address byte survives until reloaded
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ext_q <= EXT_RESET;
        else if (exec && is_ldext)
            ext_q <= b3_q; // [RL15]
    end

    // Self-timed write delay; ready shows only after it runs out
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            timer_q <= '0;
        else if (writes_ok && is_erase)
            timer_q <= WAIT_ERASE;
        else if (writes_ok && is_wrpg)
            timer_q <= WAIT_FLASH; // [RL14]
        else if (writes_ok && is_wree)
            timer_q <= WAIT_EEPROM; // [RL17]
        else if (timer_q != '0)
            timer_q <= timer_q - TMR_W'(1);
    end

    // Status pins
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ready_q <= 1'b1;
            normal_q <= 1'b1;
        end
        else
        begin
            ready_q <= !busy;
            normal_q <= rstn_s2_q; // [RL19]
        end
    end

    assign write_ready_indication = ready_q;
    assign prog_mode = en_q;
    assign normal_run = normal_q;

    // Read and EEPROM address captured as the third byte lands
    assign ee_full = (EE_AW+BYTE_W)'({b2_q, core.rx_byte});
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            core.fl_rd_addr <= '0;
            core.ee_addr <= '0;
        end
        else if (core.byte_vld && (idx_q == IDX_ADDR_LO))
        begin
            core.fl_rd_addr <= flash_word(ext_q, b2_q, core.rx_byte); // [RL18]
            core.ee_addr <= ee_full[EE_AW-1:0];
        end
    end

    // Memory commands, each a single-cycle pulse
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            core.ld_en <= 1'b0;
            core.ld_hi <= 1'b0;
            core.ld_word <= '0;
            core.ld_data <= '0;
            core.page_go <= 1'b0;
            core.page_addr <= '0;
            core.erase_go <= 1'b0;
            core.ee_we <= 1'b0;
            core.ee_wdata <= '0;
        end
        else
        begin
            core.ld_en <= writes_ok && is_ldpg; // [RL2] [RL12]
            core.page_go <= writes_ok && is_wrpg; // [RL2] [RL14]
            core.erase_go <= writes_ok && is_erase; // [RL2] [RL6]
            core.ee_we <= writes_ok && is_wree; // [RL2] [RL17]
            if (writes_ok)
            begin
                core.ld_hi <= b1_q[OP_HI_POS];
                core.ld_word <= b3_q[PAGE_WORD_POS +: PAGE_AW]; // [RL12]
                core.ld_data <= core.rx_byte;
                core.page_addr <= flash_word(ext_q, b2_q, b3_q); // [RL14] [RL15]
                core.ee_wdata <= core.rx_byte;
            end
        end
    end

    // Outgoing byte choice; reads need two cycles for address and array
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            vld_d1_q <= 1'b0;
            vld_d2_q <= 1'b0;
            sel_rd_q <= 1'b0;
            sel_fl_q <= 1'b0;
            sel_hi_q <= 1'b0;
            echo_q <= TX_RESET;
        end
        else
        begin
            vld_d1_q <= core.byte_vld && session;
            vld_d2_q <= vld_d1_q;
            if (core.byte_vld)
            begin
                echo_q <= core.rx_byte; // [RL10]
                sel_rd_q <= (idx_q == IDX_ADDR_LO) && en_q && (is_rdfl || is_rdee); // [RL18] [RL22]
                sel_fl_q <= is_rdfl;
                sel_hi_q <= b1_q[OP_HI_POS];
            end
        end
    end

    // Loaded three cycles after the byte lands, ahead of the next falling edge only if the high phase lasts four or more CPU clocks
    assign core.tx_load = vld_d2_q; // [RL4]
    always_comb
    begin
        if (!sel_rd_q)
            core.tx_byte = echo_q; // [RL10]
        else if (!sel_fl_q)
            core.tx_byte = core.ee_rd_q; // [RL18]
        else if (sel_hi_q)
            core.tx_byte = core.fl_rd_q[WORD_W-1:BYTE_W]; // [RL18]
        else
            core.tx_byte = core.fl_rd_q[BYTE_W-1:0]; // [RL18]
    end
endmodule : sispp_top
`default_nettype wire

/* sispp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sispp_checker
#(
    parameter int WAIT_FLASH_CYC_P = 20000,
    parameter int WAIT_EEPROM_CYC_P = 20000,
    parameter int WAIT_ERASE_CYC_P = 20000
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_n_pin,
    input wire logic sck,
    input wire logic serial_program_in,
    input wire logic serial_program_out,
    input wire logic write_ready_indication,
    input wire logic prog_mode,
    input wire logic normal_run
);
    // Bound on one busy stretch: all three wait times added, with slack for the pipeline
    localparam int BUSY_MAX = WAIT_ERASE_CYC_P + WAIT_FLASH_CYC_P + WAIT_EEPROM_CYC_P + 4;
    logic [31:0] busy_cnt_q;

    // Counts cycles of one busy stretch
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            busy_cnt_q <= 32'h0;
        else if (write_ready_indication)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_sdo_idle_low: assert property (normal_run [*3] |-> serial_program_out == 1'b0)
        else $error("serial out not low outside session");
    a_run_tracks_low: assert property (!reset_n_pin [*5] |-> !normal_run)
        else $error("normal run while reset pin low");
    a_run_tracks_high: assert property (reset_n_pin [*5] |-> normal_run)
        else $error("normal run missing after reset pin high");
    a_mode_off_run: assert property (normal_run && $past(normal_run, 2) |-> !prog_mode)
        else $error("programming mode kept after session end");
    a_sdo_on_fall: assert property ($changed(serial_program_out) && !normal_run |-> !sck && !$past(sck))
        else $error("serial out changed away from a falling clock");
    a_enable_on_rise: assert property ($rose(prog_mode) |-> sck && !$past(sck, 12))
        else $error("enable not tied to a rising serial clock");
    a_busy_needs_mode: assert property ($fell(write_ready_indication) |-> prog_mode)
        else $error("write started without programming enable");
    a_busy_min_len: assert property ($fell(write_ready_indication) |=> !write_ready_indication [*8])
        else $error("busy stretch too short");
    a_busy_bounded: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("busy stretch too long");

    c_enable: cover property ($rose(prog_mode));
    c_write: cover property ($fell(write_ready_indication));
    c_end: cover property ($rose(normal_run));
endmodule : sispp_checker

bind sispp_top sispp_checker #(.WAIT_FLASH_CYC_P(WAIT_FLASH_CYC_P), .WAIT_EEPROM_CYC_P(WAIT_EEPROM_CYC_P),
    .WAIT_ERASE_CYC_P(WAIT_ERASE_CYC_P)) chk_u (.ref_clk(ref_clk), .rst(rst), .reset_n_pin(reset_n_pin),
    .sck(sck), .serial_program_in(serial_program_in), .serial_program_out(serial_program_out),
    .write_ready_indication(write_ready_indication), .prog_mode(prog_mode), .normal_run(normal_run));
`default_nettype wire

/* sispp_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sispp_prog_model
(
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    // Clock idles low from power-up and between frames
    initial
    begin
        sck = 1'b0;
        sdi = 1'b0;
    end

    // One instruction, always all four bytes, MSB first
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        #3;
        for (int i = 31; i >= 0; i--)
        begin
            sdi = tx[i];
            #80;
            sck = 1'b1; // 80 ns phases, far above three CPU clocks
            rx[i] = sdo;
            #80;
            sck = 1'b0;
        end
        // Released data line shows the inverse so a stale bit cannot pass
        #20;
        sdi = ~sdi;
    endtask : xfer
endmodule : sispp_prog_model
`default_nettype wire

/* test_serial_isp_programming_port.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_isp_programming_port;
    import sispp_pkg::*;
    // Short write delays keep the run brief; erase must outlast its 16384 cycle walk
    localparam int WF = 400;
    localparam int WE = 400;
    localparam int WC = 17000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_n_pin = 1'b0;
    logic sck;
    logic serial_program_in;
    logic serial_program_out;
    logic write_ready_indication;
    logic prog_mode;
    logic normal_run;
    logic [31:0] rx;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int ee_m[int];
    int fl_m[int];
    int pb[int];
    int seed_v, a, d, p, w;

    always #2.5 ref_clk = ~ref_clk;

    sispp_top #(.WAIT_FLASH_CYC_P(WF), .WAIT_EEPROM_CYC_P(WE), .WAIT_ERASE_CYC_P(WC)) dut_u (.ref_clk(ref_clk),
        .rst(rst), .reset_n_pin(reset_n_pin), .sck(sck), .serial_program_in(serial_program_in),
        .serial_program_out(serial_program_out), .write_ready_indication(write_ready_indication),
        .prog_mode(prog_mode), .normal_run(normal_run));
    sispp_prog_model prog_u (.sck(sck), .sdi(serial_program_in), .sdo(serial_program_out));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    // Cuts a hang short
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            err_count++;
            conclude();
        end
    end

    task automatic instr(input logic [31:0] tx);
        @(posedge ref_clk);
        prog_u.xfer(tx, rx);
        // Outputs are looked at half a cycle after they settle
        repeat (8) @(negedge ref_clk);
    endtask : instr

    // Polls ready instead of a fixed delay
    task automatic wait_ready();
        int n;
        n = 0;
        while (write_ready_indication !== 1'b1 && n < 20000)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("ready", {15'h0, write_ready_indication}, 16'h1);
    endtask : wait_ready

    task automatic rd_ee(input int ad);
        instr({OP_RD_EE, 6'h0, 2'(ad >> 8), 8'(ad), 8'h00});
        check("eeprom", {8'h0, rx[7:0]}, 16'(ee_m.exists(ad) ? ee_m[ad] : 255));
    endtask : rd_ee

    task automatic wr_ee(input int ad, input int dv);
        instr({OP_WR_EE, 6'h0, 2'(ad >> 8), 8'(ad), 8'(dv)});
        wait_ready();
        ee_m[ad] = dv;
        rd_ee(ad);
    endtask : wr_ee

    task automatic rd_fl(input int wa);
        logic [15:0] e;
        e = fl_m.exists(wa) ? 16'(fl_m[wa]) : ERASED_WORD;
        instr({OP_RD_FLASH, 2'h0, 6'(wa >> 8), 8'(wa), 8'h00});
        check("flash lo", {8'h0, rx[7:0]}, {8'h0, e[7:0]});
        instr({OP_RD_FLASH | OP_HI_MASK, 2'h0, 6'(wa >> 8), 8'(wa), 8'h00});
        check("flash hi", {8'h0, rx[7:0]}, {8'h0, e[15:8]});
    endtask : rd_fl

    initial
    begin
        seed_v = $urandom(99427);
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset pin pulse with the serial clock low, then the session opens
        repeat (4) @(posedge ref_clk);
        reset_n_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        reset_n_pin <= 1'b0;
        repeat (10) @(posedge ref_clk); // Power-up wait cut short; the port does not time it
        // Before enable: writes and erase ignored, bytes still echo
        instr({OP_WR_EE, 24'h00055a});
        check("pre echo", {8'h0, rx[23:16]}, {8'h0, OP_WR_EE});
        instr({OP_PROG_EN1, 8'h80, 16'h0});
        check("pre ready", {15'h0, write_ready_indication}, 16'h1);
        check("pre mode", {15'h0, prog_mode}, 16'h0);
        instr({OP_PROG_EN1, OP_PROG_EN2, 16'h0});
        check("en echo", {8'h0, rx[15:8]}, {8'h0, OP_PROG_EN2});
        check("en mode", {15'h0, prog_mode}, 16'h1);
        // Erase with random don't-care bits
        instr({OP_PROG_EN1, 3'h4, 5'($urandom), 16'($urandom)});
        check("erase busy", {15'h0, write_ready_indication}, 16'h0);
        wait_ready();
        ee_m.delete();
        fl_m.delete();
        rd_ee(5);
        rd_ee($urandom_range(1023));
        rd_fl($urandom_range(16383));
        // Each byte written over an old value with no erase between
        repeat (2)
        begin
            a = $urandom_range(1023);
            wr_ee(a, 0);
            wr_ee(a, $urandom_range(255));
        end
        // One page: low byte before high byte of each word
        instr({OP_LOAD_EXT, 24'h0});
        p = $urandom_range(127);
        repeat (3)
        begin
            w = $urandom_range(127);
            d = $urandom_range(65535);
            instr({OP_LD_PAGE, 8'h00, 8'(w), 8'(d)});
            instr({OP_LD_PAGE | OP_HI_MASK, 8'h00, 8'(w), 8'(d >> 8)});
            pb[w] = d;
        end
        instr({OP_WR_PAGE, 2'h0, 6'(p >> 1), 1'(p), 7'h0, 8'h00});
        wait_ready();
        foreach (pb[k])
            fl_m[p * 128 + k] = pb[k];
        foreach (pb[k])
            rd_fl(p * 128 + k);
        // Session end: enable no longer taken, output held low
        @(posedge ref_clk);
        reset_n_pin <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check("run", {15'h0, normal_run}, 16'h1);
        instr({OP_PROG_EN1, OP_PROG_EN2, 16'h0});
        check("run mode", {15'h0, prog_mode}, 16'h0);
        check("run out", rx[15:0], 16'h0);
        conclude();
    end
endmodule : test_serial_isp_programming_port
`default_nettype wire
